// >>> rtl/blis_defines.svh
// Offsets, field positions and reset values of the boot-load status block
`ifndef BLIS_DEFINES_SVH
`define BLIS_DEFINES_SVH
`define BLIS_ADDR_W 16
`define BLIS_OFS_RSVD_A 16'h021A
`define BLIS_OFS_RSVD_B 16'h021B
`define BLIS_OFS_RSVD_C 16'h021C
`define BLIS_OFS_RSVD_D 16'h021D
`define BLIS_OFS_BOOT_FAIL 16'h021E
`define BLIS_OFS_ROM_LOAD 16'h021F
`define BLIS_BIT_BOOT_FAILED 0
`define BLIS_BIT_LOAD_DONE 0
`define BLIS_BIT_CHECKSUM_OK 3
`define BLIS_RST_BOOT_FAILED 1'b0
`define BLIS_RST_LOAD_DONE 1'b0
`define BLIS_RST_CHECKSUM_OK 1'b1
`define BLIS_RST_PIN_LEVEL 1'b1
`define BLIS_RSVD_READ 8'h00
`endif

// >>> rtl/blis_pkg.sv
// Types shared by the boot-load status block
package blis_pkg;
   typedef enum logic [1:0] {
      ST_START,
      ST_WAIT,
      ST_DONE
   } blis_state_t;
   typedef logic [7:0] blis_byte_t;
endpackage : blis_pkg

// >>> rtl/blis_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`include "blis_defines.svh"
module blis_sync (
   input wire logic clk,    // Core clock
   input wire logic rst,    // Async reset, active high
   input wire logic din,    // Asynchronous pin level
   output logic dout        // Filtered level in clk domain
);
   logic ff1_reg;
   logic ff2_reg;
   logic ff3_reg;
   logic level_reg;
   wire agree = (ff2_reg == ff3_reg);

   // Only the second stage reads the first; level moves once 2 and 3 agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ff1_reg <= `BLIS_RST_PIN_LEVEL;
         ff2_reg <= `BLIS_RST_PIN_LEVEL;
         ff3_reg <= `BLIS_RST_PIN_LEVEL;
         level_reg <= `BLIS_RST_PIN_LEVEL;
      end else begin
         ff1_reg <= din;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         if (agree) begin
            level_reg <= ff3_reg;
         end
      end
   end

   assign dout = level_reg;
endmodule : blis_sync

// >>> rtl/blis_top.sv
// Boot-load status flags, host port lock and interrupt summary
//
// Functional notes
// - Summary bit and pin follow enabled status
// - Read failure sets sticky failed flag
// - Checksum-ok low after CRC failure
// - CRC failure locks host port until reset
// - Read completion sets sticky done flag
`timescale 1ns/1ps
`include "blis_defines.svh"
module blis_top
   import blis_pkg::*;
#(
   parameter int IRQ_W = 8
) (
   input wire logic CORE_CLK,                  // Core clock, 100 MHz
   input wire logic RST,                       // Async reset, active high
   input wire logic RESET_PIN_N,               // Device reset pin
   output logic LOAD_START,                    // Start load pulse
   input wire logic LOAD_CPL,                  // Load cycle completed
   input wire logic LOAD_READ_ERR,             // Reading the ROM failed
   input wire logic LOAD_CRC_ERR,              // ROM read, CRC bad
   input wire logic [IRQ_W-1:0] IRQ_SRC_STATUS, // Interrupt status bits
   input wire logic [IRQ_W-1:0] IRQ_SRC_ENABLE, // Interrupt enables
   output logic IRQ_SUMMARY,                   // Summary status bit
   output logic IRQ_PIN_N_O,                   // Interrupt pin level
   output logic IRQ_PIN_N_OE,                  // Interrupt pin drive
   output logic HOST_PORT_LOCKED,              // Host port locked
   input wire logic REG_REQ,                   // Register access request
   input wire logic REG_WE,                    // Write when high
   input wire logic [`BLIS_ADDR_W-1:0] REG_ADDR, // Register address
   input wire logic [7:0] REG_WDATA,           // Write data
   output logic [7:0] REG_RDATA,               // Read data
   output logic REG_ACK                        // Access answered
);

   function automatic logic addr_is(input logic [`BLIS_ADDR_W-1:0] a,
                                    input logic [`BLIS_ADDR_W-1:0] ofs);
      addr_is = (a == ofs);
   endfunction : addr_is

   blis_state_t state_reg;
   blis_state_t state_next;
   logic pin_level;
   logic done_reg;
   logic done_next;
   logic fail_reg;
   logic fail_next;
   logic crc_ok_reg;
   logic crc_ok_next;
   logic lock_reg;
   logic lock_next;
   logic irq_reg;
   logic irq_next;
   blis_byte_t rdata_reg;
   blis_byte_t rdata_next;
   logic ack_reg;
   logic ack_next;

   // Pin reset is a device reset, so it clears what only reset may clear
   blis_sync u_pin_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .din(RESET_PIN_N),
      .dout(pin_level)
   );
   wire pin_rst = ~pin_level;

   // Load sequencing: start once after each reset release
   wire start_fire = (state_reg == ST_START) && !pin_rst;
   always_comb begin
      state_next = state_reg;
      if (pin_rst) begin
         state_next = ST_START;
      end else begin
         unique case (state_reg)
            ST_START: state_next = ST_WAIT;
            ST_WAIT: begin
               if (LOAD_CPL) begin
                  state_next = ST_DONE;
               end
            end
            ST_DONE: state_next = ST_DONE;
         endcase
      end
   end
   assign LOAD_START = start_fire;

   // Sticky flags: a set in the clearing cycle wins over the pin reset
   // done flag sticky
   assign done_next = LOAD_CPL | (done_reg & ~pin_rst);
   assign fail_next = LOAD_READ_ERR | (fail_reg & ~pin_rst);
   assign crc_ok_next = ~LOAD_CRC_ERR & (crc_ok_reg | pin_rst);
   assign lock_next = LOAD_CRC_ERR | (lock_reg & ~pin_rst);

   assign irq_next = |(IRQ_SRC_STATUS & IRQ_SRC_ENABLE);

   // Register port decode; a locked port gives no answer at all
   // Write data is unused on purpose: every writable bit here is reserved
   wire hit_fail = addr_is(REG_ADDR, `BLIS_OFS_BOOT_FAIL);
   wire hit_load = addr_is(REG_ADDR, `BLIS_OFS_ROM_LOAD);
   wire take = REG_REQ && !lock_reg;
   wire [7:0] fail_byte = {7'h00, fail_reg};
   wire [7:0] load_byte = {4'h0, crc_ok_reg, 2'h0, done_reg};
   wire [7:0] read_byte = hit_fail ? fail_byte :
                          hit_load ? load_byte : `BLIS_RSVD_READ;
   assign ack_next = take;
   assign rdata_next = (take && !REG_WE) ? read_byte : 8'h00;

   // State, flags and answers
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_reg <= ST_START;
         done_reg <= `BLIS_RST_LOAD_DONE;
         fail_reg <= `BLIS_RST_BOOT_FAILED;
         crc_ok_reg <= `BLIS_RST_CHECKSUM_OK;
         lock_reg <= 1'b0;
         irq_reg <= 1'b0;
         rdata_reg <= 8'h00;
         ack_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         done_reg <= done_next;
         fail_reg <= fail_next;
         crc_ok_reg <= crc_ok_next;
         lock_reg <= lock_next;
         irq_reg <= irq_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
      end
   end

   // Open-drain pin: only ever pulled low, released otherwise
   assign IRQ_SUMMARY = irq_reg;
   assign IRQ_PIN_N_O = 1'b0;
   assign IRQ_PIN_N_OE = irq_reg;
   assign HOST_PORT_LOCKED = lock_reg;
   assign REG_RDATA = rdata_reg;
   assign REG_ACK = ack_reg;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_load_ok;
      LOAD_CPL && !LOAD_CRC_ERR && !pin_rst;
   endsequence

   // Pin reset seen, then released: the loader has to be restarted
   sequence s_pin_release;
      pin_rst ##1 !pin_rst;
   endsequence

   // A read of the failure byte taken on this edge
   sequence s_fail_read;
      REG_REQ && !REG_WE && !lock_reg && hit_fail;
   endsequence

   // A read of a reserved or unmapped address taken on this edge
   sequence s_rsvd_read;
      REG_REQ && !REG_WE && !lock_reg && !hit_fail && !hit_load;
   endsequence

   a_irq_summary: assert property (
      ##1 (IRQ_SUMMARY ==
           |($past(IRQ_SRC_STATUS) & $past(IRQ_SRC_ENABLE)))
         && (IRQ_PIN_N_OE == IRQ_SUMMARY))
      else $error("interrupt summary does not follow enabled status");

   a_fail_sticky: assert property (
      (LOAD_READ_ERR || (fail_reg && !pin_rst)) |=> fail_reg)
      else $error("boot failed flag lost");

   a_crc_flag: assert property (
      LOAD_CRC_ERR |=> !crc_ok_reg ##0 (load_byte[3] == 1'b0))
      else $error("checksum ok flag not cleared on CRC error");

   a_lock_refuse: assert property (
      (lock_reg && !pin_rst) [*2] |=> !REG_ACK)
      else $error("locked host port answered an access");

   a_lock_set: assert property (
      LOAD_CRC_ERR |=> HOST_PORT_LOCKED)
      else $error("CRC error did not lock host port");

   a_done_sticky: assert property (
      s_load_ok |=> done_reg ##1 (done_reg || $past(pin_rst)))
      else $error("load done flag lost");

   a_read_map: assert property (
      (REG_REQ && !REG_WE && !lock_reg && hit_load) |=>
         REG_ACK && (REG_RDATA == {4'h0, $past(crc_ok_reg), 2'h0,
                                   $past(done_reg)}))
      else $error("load status read back wrong");

   // Retry after a pin reset: exactly one start pulse at release
   a_load_retry: assert property (
      s_pin_release |-> LOAD_START ##1 !LOAD_START)
      else $error("load not restarted once after pin reset");

   // A longer start would make the loader begin twice
   a_start_single: assert property (
      LOAD_START |=> !LOAD_START)
      else $error("load start held for more than one cycle");

   // Failure byte carries the sticky flag in its lowest bit only
   a_fail_map: assert property (
      s_fail_read |=> REG_ACK
         && (REG_RDATA[`BLIS_BIT_BOOT_FAILED] == $past(fail_reg))
         && (REG_RDATA[7:1] == 7'h00))
      else $error("boot failed byte read back wrong");

   // Reserved bits carry no state, so they read as a fixed pattern
   a_rsvd_read: assert property (
      s_rsvd_read |=> REG_ACK && (REG_RDATA == `BLIS_RSVD_READ))
      else $error("reserved address read back nonzero");

   // Pin reset clears the done flag unless a completion lands with it
   a_done_clear: assert property (
      (pin_rst && !LOAD_CPL) |=> !done_reg)
      else $error("load done flag survived a pin reset");

   // Pin reset without a CRC error restores the flag and frees the port
   a_crc_restore: assert property (
      (pin_rst && !LOAD_CRC_ERR) |=> crc_ok_reg && !HOST_PORT_LOCKED)
      else $error("checksum flag or lock survived a pin reset");

   // No accepted request means no answer and a quiet data bus
   a_idle_quiet: assert property (
      !(REG_REQ && !lock_reg) |=> !REG_ACK && (REG_RDATA == 8'h00))
      else $error("answer given without an accepted request");

endmodule : blis_top

// >>> verif/blis_loader_model.sv
// Loader stand-in that answers each start pulse
`timescale 1ns/1ps
module blis_loader_model (
   input wire logic clk,        // Core clock
   input wire logic start,      // Start pulse
   input wire logic [1:0] mode, // 0 ok, 1 read fail, 2 CRC fail
   output logic cpl,            // Completion pulse
   output logic rd_err,         // Read failure pulse
   output logic crc_err         // CRC failure pulse
);
   logic [2:0] cnt_reg = 3'h0;
   // Answer late, as a slow ROM would
   always @(posedge clk) begin
      cnt_reg <= start ? 3'h4 : cnt_reg - {2'h0, cnt_reg != 3'h0};
   end
   assign cpl = cnt_reg == 3'h1;
   assign rd_err = cpl && mode == 2'h1;
   assign crc_err = cpl && mode == 2'h2;
endmodule : blis_loader_model

// >>> verif/blis_top_tb_top.sv
// Self-checking bench for the boot-load status block
`timescale 1ns/1ps
module blis_top_tb_top import blis_pkg::*;;
   logic clk = 1'b0, rst = 1'b1, pin_n = 1'b1, req = 1'b0, we = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] sts = 8'h00, ena = 8'h00, rdata;
   logic [7:0] ena_tab [3] = '{8'h03, 8'h80, 8'h00};
   logic start, cpl, rd_err, crc_err, summ, pin_o, pin_oe, locked, ack;
   logic [1:0] mode = 2'h0;
   int err_count = 0, n_tests = 0, cycles = 0;
   always #5 clk = ~clk;
   blis_top u_blis_top (.CORE_CLK(clk), .RST(rst), .RESET_PIN_N(pin_n),
      .LOAD_START(start), .LOAD_CPL(cpl), .LOAD_READ_ERR(rd_err),
      .LOAD_CRC_ERR(crc_err), .IRQ_SRC_STATUS(sts), .IRQ_SRC_ENABLE(ena),
      .IRQ_SUMMARY(summ), .IRQ_PIN_N_O(pin_o), .IRQ_PIN_N_OE(pin_oe),
      .HOST_PORT_LOCKED(locked), .REG_REQ(req), .REG_WE(we),
      .REG_ADDR(addr), .REG_WDATA(8'h00), .REG_RDATA(rdata), .REG_ACK(ack));
   blis_loader_model u_blis_loader_model (.clk(clk), .start(start),
      .mode(mode), .cpl(cpl), .rd_err(rd_err), .crc_err(crc_err));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One request; the answer stands in the cycle after the taking edge
   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [7:0] ea, input logic [7:0] ed);
      @(negedge clk);
      req = 1'b1;
      we = w;
      addr = a;
      @(negedge clk);
      req = 1'b0;
      chk({7'h00, ack}, ea);
      chk(rdata, ed);
   endtask : acc
   // Pin reset with the next load outcome chosen
   task automatic pin_reset(input logic [1:0] m);
      mode = m;
      pin_n = 1'b0;
      repeat (6) @(negedge clk);
      pin_n = 1'b1;
      repeat (14) @(negedge clk);
   endtask : pin_reset
   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (12) @(negedge clk);
      acc(1'b0, 16'h021F, 8'h01, 8'h09);
      acc(1'b0, 16'h021E, 8'h01, 8'h00);
      acc(1'b1, 16'h021A, 8'h01, 8'h00);
      acc(1'b0, 16'h0300, 8'h01, 8'h00);
      sts = 8'h84;
      foreach (ena_tab[i]) begin
         ena = ena_tab[i];
         repeat (2) @(negedge clk);
         chk({pin_o, 5'h00, summ, pin_oe}, {6'h00, {2{|(sts & ena)}}});
      end
      pin_reset(2'h1);
      acc(1'b0, 16'h021E, 8'h01, 8'h01);
      acc(1'b0, 16'h021F, 8'h01, 8'h09);
      pin_reset(2'h2);
      chk({7'h00, locked}, 8'h01);
      acc(1'b0, 16'h021F, 8'h00, 8'h00);
      pin_reset(2'h0);
      acc(1'b0, 16'h021F, 8'h01, 8'h09);
      acc(1'b0, 16'h021E, 8'h01, 8'h00);
      tally_and_finish();
   end
endmodule : blis_top_tb_top
